// ### inc/osdc_map.svh
// Register offsets, field positions, reset values and timing counts for output sync control
// ----------------------------------------------------------------------------
// Overview of operation
// (RULE_01) Post-divider code 0/1 divides by 3, up to code 9 by 11; reset 6.
// (RULE_02) Software writes only post-divider codes 0 to 9; others undefined.
// (RULE_03) Sync source bit: 0 direct sync path (reset), 1 active reference.
// (RULE_04) Auto sync: 00 off, 01 frequency lock, 10 phase lock, 11 reserved.
// (RULE_05) Override clear: sync stays disabled until analog loop calibrated and locked.
// (RULE_06) After calibration and lock, sync is armed and follows source and auto mode.
// (RULE_07) Override set: analog loop lock ignored; settings control sync regardless.
// (RULE_08) Mask bit 1 releases channel B divider from static sync state.
// (RULE_09) Masked channel B divider ignores all sync events and keeps dividing.
// (RULE_10) Mask bit 0 releases channel A divider from static sync state.
// (RULE_11) Masked channel A divider ignores all sync events and keeps dividing.
// (RULE_12) Mask bits never enable output drivers; format controls do that.
// (RULE_13) Channel A format: 000 off, 001 HSTL reset, 010 LVDS, 100 CMOS both.
// (RULE_14) Format 101 CMOS positive pin only; 110 CMOS negative pin only.
// (RULE_15) Channel A polarity field sits at format register bits 3 to 2.
// (RULE_16) Polarity codes: 00 P/N, 01 P/P, 10 N/P, 11 N/N.
// (RULE_17) Sync holds unmasked dividers, then releases them together, phase aligned.
// ----------------------------------------------------------------------------
`ifndef OSDC_MAP_SVH
`define OSDC_MAP_SVH
`define OSDC_ADDR_POST_DIV 12'h424
`define OSDC_ADDR_SYNC_SRC 12'h425
`define OSDC_ADDR_GATE_MASK 12'h426
`define OSDC_ADDR_FMT_A 12'h427
`define OSDC_RST_POST_DIV 4'h4
`define OSDC_RST_SYNC_SRC 3'h0
`define OSDC_RST_GATE_MASK 3'h0
`define OSDC_RST_FMT_A 3'h1
`define OSDC_RST_POL_A 2'h0
`define OSDC_BIT_SRC 2
`define OSDC_BIT_OVERRIDE 2
`define OSDC_BIT_MASK_B 1
`define OSDC_BIT_MASK_A 0
`define OSDC_FMT_LSB 4
`define OSDC_POL_LSB 2
`define OSDC_SYNC_HOLD_CYCLES 4'h4
`endif

// ### inc/osdc_pkg.sv
// Types for the output sync and distribution control block
package osdc_pkg;
  typedef enum logic [1:0] {
    OSDC_AUTO_OFF = 2'b00,
    OSDC_AUTO_FREQ = 2'b01,
    OSDC_AUTO_PHASE = 2'b10,
    OSDC_AUTO_RSVD = 2'b11
  } osdc_auto_t;
  typedef enum logic [2:0] {
    OSDC_FMT_OFF = 3'b000,
    OSDC_FMT_HSTL = 3'b001,
    OSDC_FMT_LVDS = 3'b010,
    OSDC_FMT_RSV3 = 3'b011,
    OSDC_FMT_CMOS = 3'b100,
    OSDC_FMT_CMOSP = 3'b101,
    OSDC_FMT_CMOSN = 3'b110,
    OSDC_FMT_RSV7 = 3'b111
  } osdc_fmt_t;
  typedef enum logic [1:0] {
    OSDC_ST_IDLE = 2'b00,
    OSDC_ST_HOLD = 2'b01,
    OSDC_ST_RELEASE = 2'b10
  } osdc_state_t;
endpackage : osdc_pkg

// ### hw/osdc_ctrl.sv
// Output sync distribution control: registers, sync gating, dividers, channel A format
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "osdc_map.svh"
module osdc_ctrl #(
  parameter int CH_DIV = 4 // Channel divide ratio after the post divider
) (
  input wire logic CLOCK, // Block clock, 10 MHz
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic CLK_EN, // Freezes all state while low
  input wire logic [11:0] AVS_ADDRESS, // Avalon byte address
  input wire logic AVS_READ, // Avalon read
  input wire logic AVS_WRITE, // Avalon write
  input wire logic [31:0] AVS_WRITEDATA, // Avalon write data
  input wire logic [3:0] AVS_BYTEENABLE, // Avalon byte enables
  output logic [31:0] AVS_READDATA, // Avalon read data
  output logic AVS_WAITREQUEST, // Avalon wait request
  input wire logic ANALOG_CAL_DONE, // Analog loop calibration done, async pin
  input wire logic ANALOG_LOCK, // Analog loop lock, async pin
  input wire logic DIGITAL_FREQ_LOCK, // Digital loop frequency lock, async
  input wire logic DIGITAL_PHASE_LOCK, // Digital loop phase lock, async
  input wire logic DIRECT_SYNC, // Direct sync request, async
  input wire logic REF_SYNC, // Sync event from active reference, async
  output logic POST_DIV_CLK, // Post divided clock enable pulse
  output logic CH_A_CLK, // Channel A divider output
  output logic CH_B_CLK, // Channel B divider output
  output logic SYNC_ARMED, // Sync function armed
  output logic CH_A_P_EN, // Channel A positive pin driver enable
  output logic CH_A_N_EN, // Channel A negative pin driver enable
  output logic CH_A_P_OUT, // Channel A positive pin level
  output logic CH_A_N_OUT, // Channel A negative pin level
  output osdc_pkg::osdc_fmt_t CH_A_MODE // Channel A driver mode
);
  import osdc_pkg::*;

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [3:0] post_div_reg;
  logic sync_src_reg;
  osdc_auto_t auto_mode_reg;
  logic override_reg;
  logic mask_b_reg;
  logic mask_a_reg;
  osdc_fmt_t fmt_a_reg;
  logic [1:0] pol_a_reg;
  logic wr_lane0;
  logic [7:0] wd;
  logic rd_pending_reg;

  assign wd = AVS_WRITEDATA[7:0];
  assign wr_lane0 = CLK_EN && AVS_WRITE && AVS_BYTEENABLE[0];
  // Reads take one wait cycle so data come from flip-flops
  assign AVS_WAITREQUEST = AVS_READ && !rd_pending_reg;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      post_div_reg <= `OSDC_RST_POST_DIV; // [RULE_01]
      sync_src_reg <= 1'b0; // [RULE_03]
      auto_mode_reg <= OSDC_AUTO_OFF; // [RULE_04]
      override_reg <= 1'b0;
      mask_b_reg <= 1'b0;
      mask_a_reg <= 1'b0;
      fmt_a_reg <= OSDC_FMT_HSTL; // [RULE_13]
      pol_a_reg <= `OSDC_RST_POL_A; // [RULE_16]
    end else if (wr_lane0) begin
      case (AVS_ADDRESS)
        `OSDC_ADDR_POST_DIV: begin
          post_div_reg <= wd[3:0];
        end
        `OSDC_ADDR_SYNC_SRC: begin
          sync_src_reg <= wd[`OSDC_BIT_SRC];
          auto_mode_reg <= osdc_auto_t'(wd[1:0]);
        end
        `OSDC_ADDR_GATE_MASK: begin
          override_reg <= wd[`OSDC_BIT_OVERRIDE];
          mask_b_reg <= wd[`OSDC_BIT_MASK_B]; // [RULE_08]
          mask_a_reg <= wd[`OSDC_BIT_MASK_A]; // [RULE_10]
        end
        `OSDC_ADDR_FMT_A: begin
          fmt_a_reg <= osdc_fmt_t'(wd[`OSDC_FMT_LSB +: 3]);
          pol_a_reg <= wd[`OSDC_POL_LSB +: 2]; // [RULE_15]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rd_pending_reg <= 1'b0;
      AVS_READDATA <= 32'h0;
    end else if (CLK_EN) begin
      rd_pending_reg <= AVS_READ && !rd_pending_reg;
      if (AVS_READ && !rd_pending_reg) begin
        case (AVS_ADDRESS)
          `OSDC_ADDR_POST_DIV: AVS_READDATA <= {28'h0, post_div_reg};
          `OSDC_ADDR_SYNC_SRC: AVS_READDATA <= {29'h0, sync_src_reg, auto_mode_reg};
          `OSDC_ADDR_GATE_MASK: AVS_READDATA <= {28'h0, SYNC_ARMED, override_reg, mask_b_reg,
                                                 mask_a_reg};
          `OSDC_ADDR_FMT_A: AVS_READDATA <= {25'h0, fmt_a_reg, pol_a_reg, 2'b00};
          default: AVS_READDATA <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] clean_reg;
  assign pins = {REF_SYNC, DIRECT_SYNC, DIGITAL_PHASE_LOCK, DIGITAL_FREQ_LOCK, ANALOG_LOCK,
                 ANALOG_CAL_DONE};

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      clean_reg <= '0;
    end else if (CLK_EN) begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Accept a change only once stages two and three agree
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          clean_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Sync qualification
  // ----------------------------------------------------------------------------
  logic [NSYNC-1:0] prev_reg;
  logic [NSYNC-1:0] rise;
  logic manual_evt;
  logic auto_evt;
  logic sync_evt;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      prev_reg <= '0;
    end else if (CLK_EN) begin
      prev_reg <= clean_reg;
    end
  end
  assign rise = clean_reg & ~prev_reg;

  // Armed only after calibration and lock, unless overridden
  assign SYNC_ARMED = override_reg || (clean_reg[0] && clean_reg[1]); // [RULE_05] [RULE_07]
  assign manual_evt = sync_src_reg ? rise[5] : rise[4]; // [RULE_03]

  always_comb begin
    case (auto_mode_reg) // [RULE_04]
      OSDC_AUTO_FREQ: auto_evt = rise[2];
      OSDC_AUTO_PHASE: auto_evt = rise[3];
      default: auto_evt = 1'b0;
    endcase
  end
  assign sync_evt = SYNC_ARMED && (manual_evt || auto_evt); // [RULE_06]

  // ----------------------------------------------------------------------------
  // Sync sequencer: hold, then release together
  // ----------------------------------------------------------------------------
  osdc_state_t state_reg;
  logic [3:0] hold_cnt_reg;
  logic hold_a;
  logic hold_b;
  logic release_pulse;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= OSDC_ST_IDLE;
      hold_cnt_reg <= 4'h0;
    end else if (CLK_EN) begin
      case (state_reg)
        OSDC_ST_IDLE: begin
          if (sync_evt) begin
            state_reg <= OSDC_ST_HOLD; // [RULE_17]
            hold_cnt_reg <= `OSDC_SYNC_HOLD_CYCLES;
          end
        end
        OSDC_ST_HOLD: begin
          if (hold_cnt_reg == 4'h1) begin
            state_reg <= OSDC_ST_RELEASE;
          end
          hold_cnt_reg <= hold_cnt_reg - 4'h1;
        end
        OSDC_ST_RELEASE: state_reg <= OSDC_ST_IDLE;
        default: state_reg <= OSDC_ST_IDLE;
      endcase
    end
  end
  assign release_pulse = (state_reg == OSDC_ST_RELEASE);
  // Masked channels never see the hold, so they keep running
  assign hold_a = (state_reg == OSDC_ST_HOLD) && !mask_a_reg; // [RULE_11]
  assign hold_b = (state_reg == OSDC_ST_HOLD) && !mask_b_reg; // [RULE_09]

  // ----------------------------------------------------------------------------
  // Post divider and channel dividers
  // ----------------------------------------------------------------------------
  logic [3:0] post_ratio;
  logic [3:0] post_cnt_reg;
  assign post_ratio = (post_div_reg < 4'h2) ? 4'h3 : (post_div_reg + 4'h2); // [RULE_01]

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      post_cnt_reg <= 4'h0;
      POST_DIV_CLK <= 1'b0;
    end else if (CLK_EN) begin
      POST_DIV_CLK <= (post_cnt_reg == 4'h0);
      post_cnt_reg <= (post_cnt_reg >= post_ratio - 4'h1) ? 4'h0 : post_cnt_reg + 4'h1;
    end
  end

  // Divider is still until released; mask clear alone keeps it parked.
  logic [7:0] cnt_a_reg;
  logic [7:0] cnt_b_reg;
  logic run_a_reg;
  logic run_b_reg;
  localparam logic [7:0] CH_LAST = 8'(CH_DIV - 1);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      run_a_reg <= 1'b0;
      cnt_a_reg <= 8'h0;
      CH_A_CLK <= 1'b0;
    end else if (CLK_EN) begin
      if (hold_a) begin
        run_a_reg <= 1'b0;
        cnt_a_reg <= 8'h0;
        CH_A_CLK <= 1'b0;
      end else begin
        if (mask_a_reg || release_pulse) begin
          run_a_reg <= 1'b1; // [RULE_10] [RULE_17]
        end
        if (run_a_reg && POST_DIV_CLK) begin
          cnt_a_reg <= (cnt_a_reg >= CH_LAST) ? 8'h0 : cnt_a_reg + 8'h1;
          CH_A_CLK <= (cnt_a_reg < 8'(CH_DIV / 2));
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      run_b_reg <= 1'b0;
      cnt_b_reg <= 8'h0;
      CH_B_CLK <= 1'b0;
    end else if (CLK_EN) begin
      if (hold_b) begin
        run_b_reg <= 1'b0;
        cnt_b_reg <= 8'h0;
        CH_B_CLK <= 1'b0;
      end else begin
        if (mask_b_reg || release_pulse) begin
          run_b_reg <= 1'b1; // [RULE_08] [RULE_17]
        end
        if (run_b_reg && POST_DIV_CLK) begin
          cnt_b_reg <= (cnt_b_reg >= CH_LAST) ? 8'h0 : cnt_b_reg + 8'h1;
          CH_B_CLK <= (cnt_b_reg < 8'(CH_DIV / 2));
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Channel A driver format and polarity
  // ----------------------------------------------------------------------------
  // Enables depend only on format, never on the sync masks
  always_comb begin
    CH_A_MODE = fmt_a_reg;
    case (fmt_a_reg) // [RULE_12] [RULE_13] [RULE_14]
      OSDC_FMT_HSTL, OSDC_FMT_LVDS, OSDC_FMT_CMOS: begin
        CH_A_P_EN = 1'b1;
        CH_A_N_EN = 1'b1;
      end
      OSDC_FMT_CMOSP: begin
        CH_A_P_EN = 1'b1;
        CH_A_N_EN = 1'b0;
      end
      OSDC_FMT_CMOSN: begin
        CH_A_P_EN = 1'b0;
        CH_A_N_EN = 1'b1;
      end
      default: begin
        CH_A_P_EN = 1'b0;
        CH_A_N_EN = 1'b0;
      end
    endcase
  end
  // High bit inverts P; N is inverted when both bits match: 00 P/N, 01 P/P, 10 N/P, 11 N/N
  assign CH_A_P_OUT = CH_A_P_EN && (CH_A_CLK ^ pol_a_reg[1]); // [RULE_16]
  assign CH_A_N_OUT = CH_A_N_EN && (CH_A_CLK ^ (pol_a_reg[1] ~^ pol_a_reg[0])); // [RULE_16]
endmodule // osdc_ctrl

// ### tb/osdc_ctrl_checker.sv
// Port assertions for the output sync distribution control block
`timescale 1ns/100ps
module osdc_ctrl_checker
  import osdc_pkg::*;
(
  input wire logic CLOCK, // Clock
  input wire logic RSTN, // Reset, active low
  input wire logic CLK_EN, // Enable
  input wire logic AVS_READ, // Read
  input wire logic AVS_WRITE, // Write
  input wire logic AVS_WAITREQUEST, // Wait
  input wire logic ANALOG_CAL_DONE, // Calibrated
  input wire logic ANALOG_LOCK, // Locked
  input wire logic POST_DIV_CLK, // Divided pulse
  input wire logic SYNC_ARMED, // Armed
  input wire logic CH_A_P_EN, // P enable
  input wire logic CH_A_N_EN, // N enable
  input wire osdc_pkg::osdc_fmt_t CH_A_MODE // Mode
);
  import osdc_pkg::*;
  default clocking dcb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);
  // ----
  // Assertions
  // ----
  a_off_pins: assert property (CH_A_MODE == OSDC_FMT_OFF |-> !CH_A_P_EN && !CH_A_N_EN)
    else $error("driver on in power-down");
  a_pair_pins: assert property (
    CH_A_MODE inside {OSDC_FMT_HSTL, OSDC_FMT_LVDS, OSDC_FMT_CMOS} |-> CH_A_P_EN && CH_A_N_EN)
    else $error("pair not driven");
  a_p_only: assert property (CH_A_MODE == OSDC_FMT_CMOSP |-> CH_A_P_EN && !CH_A_N_EN)
    else $error("wrong pin for P only");
  a_n_only: assert property (CH_A_MODE == OSDC_FMT_CMOSN |-> !CH_A_P_EN && CH_A_N_EN)
    else $error("wrong pin for N only");
  a_mode_held: assert property (
    !(AVS_WRITE && !AVS_WAITREQUEST) |=> $stable(CH_A_MODE))
    else $error("mode moved without write");
  a_armed_lock: assert property (
    (CLK_EN && ANALOG_CAL_DONE && ANALOG_LOCK) [*8] |-> SYNC_ARMED)
    else $error("not armed after lock");
  a_pulse_gap: assert property (POST_DIV_CLK |=> !POST_DIV_CLK [*2])
    else $error("post divide below three");
  a_write_ready: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("write stalled");
  a_read_wait: assert property (AVS_READ && !$past(AVS_READ) |-> AVS_WAITREQUEST)
    else $error("read answered early");
  c_armed: cover property (SYNC_ARMED);
  c_cmosn: cover property (CH_A_MODE == OSDC_FMT_CMOSN);
  c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule // osdc_ctrl_checker

bind osdc_ctrl osdc_ctrl_checker u_osdc_ctrl_checker (.CLOCK(CLOCK), .RSTN(RSTN),
  .CLK_EN(CLK_EN), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .ANALOG_CAL_DONE(ANALOG_CAL_DONE),
  .ANALOG_LOCK(ANALOG_LOCK), .POST_DIV_CLK(POST_DIV_CLK), .SYNC_ARMED(SYNC_ARMED),
  .CH_A_P_EN(CH_A_P_EN), .CH_A_N_EN(CH_A_N_EN), .CH_A_MODE(CH_A_MODE));

// ### tb/osdc_rx_model.sv
// Downstream clock receiver model: counts rising edges of both channel clocks
`timescale 1ns/100ps
module osdc_rx_model (
  input wire logic clk, // Sampling clock
  input wire logic clr, // Clears both counts
  input wire logic ch_a, // Channel A clock
  input wire logic ch_b, // Channel B clock
  output int a_edges, // Channel A rising edges
  output int b_edges // Channel B rising edges
);
  logic a_d = 1'b0;
  logic b_d = 1'b0;
  // Sampled, so pulses shorter than a cycle go unseen
  always @(posedge clk) begin
    a_d <= ch_a;
    b_d <= ch_b;
    a_edges <= clr ? 0 : a_edges + int'(ch_a && !a_d);
    b_edges <= clr ? 0 : b_edges + int'(ch_b && !b_d);
  end
endmodule // osdc_rx_model

// ### tb/tb.sv
// Self-checking bench for the output sync distribution control block
`timescale 1ns/100ps
module tb;
  import osdc_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] wd; logic [7:0] rd; logic [1:0] en;} osdc_rrow_t;
  typedef struct {logic [7:0] cfg; int good; int bad;} osdc_mrow_t;
  logic clock, wait_req, pd, cha, chb, armed, pen, nen, pout, nout, skew;
  logic rstn = 1'b0, rd = 1'b0, wr = 1'b0, clr = 1'b1;
  logic [3:0] be = 4'hf, trig = 4'h0;
  logic [1:0] lock = 2'b00;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  osdc_fmt_t mode;
  int a_edges, b_edges, p, mismatches = 0, check_count = 0;
  // Address, written, read back, pin enables
  osdc_rrow_t rrow [11] = '{'{12'h424, 8'h09, 8'h09, 2'b11}, '{12'h424, 8'h00, 8'h00, 2'b11},
    '{12'h425, 8'h06, 8'h06, 2'b11}, '{12'h425, 8'h01, 8'h01, 2'b11},
    '{12'h428, 8'h5a, 8'h00, 2'b11}, '{12'h427, 8'h00, 8'h00, 2'b00},
    '{12'h427, 8'h14, 8'h14, 2'b11}, '{12'h427, 8'h28, 8'h28, 2'b11},
    '{12'h427, 8'h4c, 8'h4c, 2'b11}, '{12'h427, 8'h50, 8'h50, 2'b10},
    '{12'h427, 8'h60, 8'h60, 2'b01}};
  // Source and auto mode, trigger that counts, trigger that must not
  osdc_mrow_t mrow [4] = '{'{8'h00, 0, 1}, '{8'h04, 1, 0}, '{8'h01, 2, 3}, '{8'h02, 3, 2}};
  osdc_ctrl #(.CH_DIV(4)) u_osdc_ctrl (.CLOCK(clock), .RSTN(rstn), .CLK_EN(1'b1),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .ANALOG_CAL_DONE(lock[0]), .ANALOG_LOCK(lock[1]), .DIRECT_SYNC(trig[0]),
    .REF_SYNC(trig[1]), .DIGITAL_FREQ_LOCK(trig[2]), .DIGITAL_PHASE_LOCK(trig[3]),
    .POST_DIV_CLK(pd), .CH_A_CLK(cha), .CH_B_CLK(chb), .SYNC_ARMED(armed),
    .CH_A_P_EN(pen), .CH_A_N_EN(nen), .CH_A_P_OUT(pout), .CH_A_N_OUT(nout),
    .CH_A_MODE(mode));
  osdc_rx_model u_osdc_rx_model (.clk(clock), .clr(clr), .ch_a(cha), .ch_b(chb),
    .a_edges(a_edges), .b_edges(b_edges));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Called just after a rising edge; request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    check(n < 20, 1'b1);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    // One idle edge so a following request never retoggles in the same step
    @(posedge clock);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    check(got, {24'h0, e});
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
  endtask
  // Channel A left running, channel B parked
  task automatic fresh(input logic ovr);
    do_reset();
    bus(1'b1, 12'h426, {5'h0, ovr, 2'b01});
    bus(1'b1, 12'h426, {5'h0, ovr, 2'b00});
  endtask
  task automatic fire(input int k);
    trig[k] <= 1'b1;
    repeat (8) @(posedge clock);
    trig[k] <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task automatic window();
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    skew = 1'b0;
    repeat (200) begin
      @(negedge clock);
      if (cha !== chb) skew = 1'b1;
    end
    @(posedge clock);
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pd !== 1'b1 && n < 40);
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    do_reset();
    foreach (rrow[i]) begin
      bus(1'b1, rrow[i].a, rrow[i].wd);
      rchk(rrow[i].a, rrow[i].rd);
      check({pen, nen}, rrow[i].en);
      check(mode, rrow[i].a == 12'h427 ? rrow[i].wd[6:4] : 3'h1);
    end
    do_reset();
    rchk(12'h424, 8'h04);
    rchk(12'h425, 8'h00);
    rchk(12'h426, 8'h00);
    rchk(12'h427, 8'h10);
    be <= 4'h0;
    bus(1'b1, 12'h424, 8'h07);
    be <= 4'hf;
    rchk(12'h424, 8'h04);
    for (int c = 0; c < 10; c++) begin // defined codes only
      bus(1'b1, 12'h424, c[7:0]);
      repeat (3) gap(p);
      check(p, c < 2 ? 3 : c + 2);
    end
    fresh(1'b0);
    check(armed, 1'b0);
    fire(0);
    window();
    check(b_edges, 0);
    lock <= 2'b01;
    fire(0);
    window();
    check(b_edges, 0);
    lock <= 2'b11;
    repeat (10) @(posedge clock);
    check(armed, 1'b1);
    fire(0);
    window();
    check(b_edges > 0, 1'b1);
    lock <= 2'b00;
    foreach (mrow[i]) begin
      fresh(1'b1);
      bus(1'b1, 12'h425, mrow[i].cfg);
      fire(mrow[i].bad);
      window();
      check(b_edges, 0);
      check(a_edges > 0, 1'b1);
      fire(mrow[i].good);
      window();
      check(b_edges > 0, 1'b1);
      check(skew, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 12'h427, {4'h4, k[1:0], 2'b00});
      skew = 1'b0;
      repeat (60) begin
        @(posedge clock);
        if (pout !== (cha ^ k[1]) || nout !== (cha ^ (k[1] ~^ k[0]))) skew = 1'b1;
      end
      check(skew, 1'b0);
    end
    // Sync every 16 cycles at ratio 11: each release leaves one post pulse, so one rise
    for (int k = 0; k < 2; k++) begin
      do_reset();
      bus(1'b1, 12'h424, 8'h09);
      bus(1'b1, 12'h427, 8'h00);
      bus(1'b1, 12'h426, k ? 8'h05 : 8'h06);
      check({pen, nen}, 2'b00);
      clr <= 1'b1;
      trig[0] <= 1'b1;
      repeat (8) @(posedge clock);
      clr <= 1'b0;
      trig[0] <= 1'b0;
      repeat (8) @(posedge clock);
      repeat (10) fire(0);
      repeat (7) @(posedge clock);
      check(k ? a_edges > 0 : b_edges > 0, 1'b1);
      check(k ? b_edges : a_edges, 11);
    end
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
endmodule // tb
